//--- hw/ivt_core.sv
// Vector and trap map: turns peripheral requests and hardware traps into
// vector addresses for the CPU core, with trap flags and service states.
// Assumes CPU handshake and peripheral requests share ref_clk.
//
// Summary of operation
// R1 - Vector table lies in the segment held by the segment select register.
// R2 - Adjacent vectors spaced by the spacing field, default four bytes.
// R3 - Vector address is segment base plus trap number times spacing.
// R4 - First serial request maps to trap 0x50, later ones consecutive.
// R5 - Last serial request maps to trap 0x61 at offset 0x184.
// R6 - External request zero maps to trap 0x68, next two follow.
// R7 - External request three maps to trap 0x6D after internal requests.
// R8 - End of transfer request maps to trap 0x6F, the highest node.
// R9 - Trap numbers 0x62 to 0x67 are reserved and never generated.
// R10 - Hardware traps vector at once and cannot be masked.
// R11 - Each hardware trap sets its own bit in the trap flag register.
// R12 - Hardware traps preempt code unless a trap service of the same or a higher class runs.
// R13 - Trap services block ordinary interrupt and event transfer preemption.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module ivt_core (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [ivt_pkg::IVT_RADDR_W-1:0] reg_addr,
    input wire logic [ivt_pkg::IVT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ivt_pkg::IVT_DATA_W-1:0] reg_rdata,
    input wire logic [ivt_pkg::IVT_NUM_SRC-1:0] src_req,
    output logic [ivt_pkg::IVT_NUM_SRC-1:0] src_ack,
    input wire logic [ivt_pkg::IVT_NUM_A-1:0] trap_a,
    input wire logic trap_b,
    output logic vec_valid,
    output logic vec_is_trap,
    output logic [ivt_pkg::IVT_TRAP_W-1:0] vec_trap,
    output logic [ivt_pkg::IVT_ADDR_W-1:0] vec_addr,
    input wire logic vec_ack,
    input wire logic svc_done,
    output logic irq
);
    import ivt_pkg::*;

    typedef struct packed {
        ivt_state_t st;
        logic [7:0] seg;
        logic [1:0] spacing;
        logic ien;
        logic [4:0] trap_flag;
        logic [4:0] pend;
        logic cls_a;
        logic [2:0] evt;
        logic [2:0] mask;
        logic vec_valid;
        logic vec_is_trap;
        logic [IVT_TRAP_W-1:0] vec_trap;
        logic [IVT_ADDR_W-1:0] vec_addr;
        logic [IVT_SRC_W-1:0] src_idx;
        logic [IVT_NUM_SRC-1:0] src_ack;
        logic [IVT_DATA_W-1:0] rdata;
        logic irq;
    } ivt_regs_t;

    ivt_regs_t r;
    ivt_regs_t next_r;
    logic map_any;
    logic [IVT_SRC_W-1:0] map_idx;
    logic [IVT_TRAP_W-1:0] map_trap;

    ivt_src_map #(.NUM_SRC(IVT_NUM_SRC)) u_map (
        .req(src_req),
        .any(map_any),
        .idx(map_idx),
        .trap(map_trap)
    );

    // Segment in the top byte, scaled trap number below it
    function automatic logic [IVT_ADDR_W-1:0] vec_of(
        input logic [7:0] seg,
        input logic [1:0] sc,
        input logic [IVT_TRAP_W-1:0] tn
    );
        logic [15:0] off;
        off = 16'({9'h0, tn} << (IVT_BASE_SHIFT + int'(sc)));
        return {seg, off};
    endfunction

    // Class A traps first, lowest index highest; class B last
    function automatic logic [IVT_TRAP_W-1:0] trap_num(input logic [4:0] p);
        logic [IVT_TRAP_W-1:0] t;
        t = IVT_TRAP_B;
        for (int i = IVT_NUM_A - 1; i >= 0; i--) begin
            if (p[i]) begin
                t = IVT_TRAP_A0 + IVT_TRAP_W'(i) * IVT_TRAP_STEP;
            end
        end
        return t;
    endfunction

    function automatic logic [4:0] first_bit(input logic [4:0] p);
        logic [4:0] o;
        o = 5'h00;
        for (int i = 4; i >= 0; i--) begin
            if (p[i]) begin
                o = 5'h00;
                o[i] = 1'b1;
            end
        end
        return o;
    endfunction

    always_comb begin
        logic [4:0] ev;
        logic [2:0] ev_set;
        logic take_trap;
        logic pend_a;
        ev = {trap_b, trap_a};
        ev_set = 3'h0;
        take_trap = 1'b0;
        next_r = r;
        next_r.src_ack = '0;
        next_r.rdata = '0;
        next_r.pend = r.pend | ev; // R10
        pend_a = |next_r.pend[IVT_NUM_A-1:0];

        case (r.st)
            IVT_IDLE, IVT_VEC_IRQ, IVT_SVC_IRQ: begin
                take_trap = |next_r.pend; // R12
            end
            IVT_SVC_TRAP: begin
                // Only a class A trap may cut into a class B service
                take_trap = !r.cls_a && pend_a; // R12
            end
            default: begin
                take_trap = 1'b0;
            end
        endcase

        if (take_trap) begin
            next_r.vec_trap = trap_num(next_r.pend);
            next_r.vec_addr = vec_of(r.seg, r.spacing, next_r.vec_trap); // R1 R3
            next_r.pend = next_r.pend & ~first_bit(next_r.pend);
            next_r.cls_a = pend_a;
            next_r.vec_valid = 1'b1;
            next_r.vec_is_trap = 1'b1;
            next_r.st = IVT_VEC_TRAP;
            ev_set[IVT_EVT_TRAP] = 1'b1;
            ev_set[IVT_EVT_PRE] = (r.st != IVT_IDLE);
        end else begin
            case (r.st)
                IVT_IDLE: begin
                    if (map_any && r.ien) begin
                        next_r.vec_trap = map_trap; // R4 R5 R6 R7 R8 R9
                        next_r.vec_addr = vec_of(r.seg, r.spacing, map_trap);
                        next_r.src_idx = map_idx;
                        next_r.vec_valid = 1'b1;
                        next_r.vec_is_trap = 1'b0;
                        next_r.st = IVT_VEC_IRQ;
                    end
                end
                IVT_VEC_IRQ: begin
                    if (vec_ack) begin
                        next_r.vec_valid = 1'b0;
                        next_r.src_ack[r.src_idx] = 1'b1;
                        next_r.st = IVT_SVC_IRQ;
                        ev_set[IVT_EVT_IRQ] = 1'b1;
                    end
                end
                IVT_SVC_IRQ: begin
                    if (svc_done) begin
                        next_r.st = IVT_IDLE;
                    end
                end
                IVT_VEC_TRAP: begin
                    if (vec_ack) begin
                        next_r.vec_valid = 1'b0;
                        next_r.st = IVT_SVC_TRAP;
                    end
                end
                IVT_SVC_TRAP: begin
                    // Peripheral requests wait here until the trap ends
                    if (svc_done) begin // R13
                        next_r.st = IVT_IDLE;
                    end
                end
                default: begin
                    next_r.st = IVT_IDLE;
                end
            endcase
        end

        // Register writes; hardware sets win over write-one clears
        if (reg_wr) begin
            if (reg_addr == IVT_REG_SEG) begin
                next_r.seg = reg_wdata[7:0];
            end else if (reg_addr == IVT_REG_CFG) begin
                next_r.spacing = reg_wdata[1:0]; // R2
                next_r.ien = reg_wdata[IVT_CFG_IEN];
            end else if (reg_addr == IVT_REG_FLAG) begin
                next_r.trap_flag = r.trap_flag & ~reg_wdata[4:0];
            end else if (reg_addr == IVT_REG_EVT) begin
                next_r.evt = r.evt & ~reg_wdata[2:0];
            end else if (reg_addr == IVT_REG_MASK) begin
                next_r.mask = reg_wdata[2:0];
            end
        end
        next_r.trap_flag = next_r.trap_flag | ev; // R11
        next_r.evt = next_r.evt | ev_set;
        next_r.irq = |(next_r.evt & next_r.mask);

        if (reg_rd) begin
            if (reg_addr == IVT_REG_SEG) begin
                next_r.rdata = {8'h00, r.seg};
            end else if (reg_addr == IVT_REG_CFG) begin
                next_r.rdata = {13'h0000, r.ien, r.spacing};
            end else if (reg_addr == IVT_REG_FLAG) begin
                next_r.rdata = {11'h000, r.trap_flag};
            end else if (reg_addr == IVT_REG_EVT) begin
                next_r.rdata = {13'h0000, r.evt};
            end else if (reg_addr == IVT_REG_MASK) begin
                next_r.rdata = {13'h0000, r.mask};
            end else if (reg_addr == IVT_REG_STAT) begin
                next_r.rdata = {r.vec_trap, r.pend, r.cls_a, r.st};
            end else begin
                next_r.rdata = '0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '{st: IVT_IDLE, seg: IVT_SEG_RST, spacing: IVT_SPACING_RST,
                   mask: IVT_MASK_RST, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign src_ack = r.src_ack;
    assign vec_valid = r.vec_valid;
    assign vec_is_trap = r.vec_is_trap;
    assign vec_trap = r.vec_trap;
    assign vec_addr = r.vec_addr;
    assign irq = r.irq;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_vec_in_segment: assert property ( // R1
        vec_valid |-> vec_addr[23:16] == r.seg)
        else $error("vector outside selected segment");
    a_default_spacing: assert property ( // R2
        (vec_valid && r.spacing == 2'h0)
        |-> vec_addr[15:0] == {7'h00, vec_trap, 2'h0})
        else $error("default spacing is not four bytes");
    a_first_serial: assert property ( // R4
        (r.st == IVT_IDLE && r.ien && src_req[10] && !(|src_req[9:0])
         && !(|r.pend) && !(|trap_a) && !trap_b && !reg_wr)
        |=> vec_trap == 7'h50)
        else $error("first serial request not trap 0x50");
    a_no_reserved: assert property ( // R9
        vec_valid && !vec_is_trap |-> (vec_trap < IVT_RSV_LO
        || vec_trap > IVT_RSV_HI) && vec_trap <= IVT_TOP_TRAP)
        else $error("reserved slot generated");
    a_trap_flag: assert property ( // R11
        trap_a[0] |=> r.trap_flag[0])
        else $error("trap flag not set");
    a_trap_at_once: assert property ( // R10
        (trap_b && r.st == IVT_SVC_IRQ && !(|trap_a)
         && !(|r.pend[IVT_NUM_A-1:0])) |=> vec_valid && vec_is_trap
        && vec_trap == IVT_TRAP_B)
        else $error("trap not taken at once");
    a_no_irq_in_trap: assert property ( // R13
        r.st == IVT_SVC_TRAP && !(|trap_a) && !(|r.pend) |=> !vec_valid
        || vec_is_trap)
        else $error("interrupt preempted a trap service");
    a_a_over_b: assert property ( // R12
        (r.st == IVT_SVC_TRAP && !r.cls_a && trap_a[0])
        |=> vec_valid && vec_is_trap && vec_trap == IVT_TRAP_A0)
        else $error("class A did not preempt class B");
    // A class A service is never cut, not even by another class A trap
    a_a_service_kept: assert property ( // R12
        (r.st == IVT_SVC_TRAP && r.cls_a) |=> !vec_valid)
        else $error("class A trap service was preempted");
    a_trap_b_flag: assert property ( // R11
        trap_b |=> r.trap_flag[IVT_FLAG_B])
        else $error("class B trap flag not set");
    a_eop_vector: assert property ( // R8
        (r.st == IVT_IDLE && r.ien && src_req[35] && !(|src_req[34:0])
         && !(|r.pend) && !(|trap_a) && !trap_b)
        |=> vec_valid && !vec_is_trap && vec_trap == IVT_TOP_TRAP)
        else $error("end of transfer request not trap 0x6F");
    a_ack_one_hot: assert property (
        $onehot0(src_ack))
        else $error("more than one source acknowledged");
    a_irq_out: assert property (
        irq == (|(r.evt & r.mask)))
        else $error("interrupt output disagrees with events");

    c_irq_served: cover property (vec_valid && !vec_is_trap ##1 vec_ack);
    c_trap_taken: cover property (r.st == IVT_SVC_TRAP ##[1:20] svc_done);
    c_preempt: cover property (r.st == IVT_SVC_IRQ ##1 r.st == IVT_VEC_TRAP);
    c_eop_vec: cover property (vec_valid && vec_trap == IVT_TOP_TRAP);
    c_spacing_eight: cover property (vec_valid && r.spacing == 2'h1);
endmodule // ivt_core

//--- hw/ivt_pkg.sv
// Shared constants and types of the interrupt vector and trap map.
// Assumes one 25 MHz clock and a plain register port with 16-bit data.
package ivt_pkg;
    localparam int IVT_NUM_SRC = 36;
    localparam int IVT_SRC_W = 6;
    localparam int IVT_TRAP_W = 7;
    localparam int IVT_ADDR_W = 24;
    localparam int IVT_DATA_W = 16;
    localparam int IVT_RADDR_W = 8;
    localparam int IVT_NUM_A = 4;

    // First peripheral group (CAN 6..15 and the 18 serial requests)
    localparam int IVT_GRP0_CNT = 28;
    localparam logic [6:0] IVT_GRP0_TRAP = 7'h46;
    // Second group (system control requests, real-time clock, end of transfer)
    localparam logic [6:0] IVT_GRP1_TRAP = 7'h68;
    localparam logic [6:0] IVT_RSV_LO = 7'h62;
    localparam logic [6:0] IVT_RSV_HI = 7'h67;
    localparam logic [6:0] IVT_TOP_TRAP = 7'h6F;

    // Hardware trap numbers
    localparam logic [6:0] IVT_TRAP_A0 = 7'h02;
    localparam logic [6:0] IVT_TRAP_STEP = 7'h02;
    localparam logic [6:0] IVT_TRAP_B = 7'h0A;

    // Spacing field: 0 gives 4 bytes, each step doubles it
    localparam logic [1:0] IVT_SPACING_RST = 2'h0;
    localparam int IVT_BASE_SHIFT = 2;

    // Register offsets
    localparam logic [7:0] IVT_REG_SEG = 8'h00;
    localparam logic [7:0] IVT_REG_CFG = 8'h04;
    localparam logic [7:0] IVT_REG_FLAG = 8'h08;
    localparam logic [7:0] IVT_REG_EVT = 8'h0C;
    localparam logic [7:0] IVT_REG_MASK = 8'h10;
    localparam logic [7:0] IVT_REG_STAT = 8'h14;

    // Field positions
    localparam int IVT_CFG_IEN = 2;
    localparam int IVT_FLAG_B = 4;
    localparam int IVT_EVT_TRAP = 0;
    localparam int IVT_EVT_IRQ = 1;
    localparam int IVT_EVT_PRE = 2;

    localparam logic [7:0] IVT_SEG_RST = 8'h00;
    localparam logic [2:0] IVT_MASK_RST = 3'h0;

    typedef enum logic [2:0] {
        IVT_IDLE = 3'b000,
        IVT_VEC_IRQ = 3'b001,
        IVT_SVC_IRQ = 3'b010,
        IVT_VEC_TRAP = 3'b011,
        IVT_SVC_TRAP = 3'b100
    } ivt_state_t;
endpackage

//--- hw/ivt_src_map.sv
// Fixed priority encoder from peripheral request lines to trap numbers.
// Assumes requests are levels from logic on the same clock.
`timescale 1ns/1ns
module ivt_src_map #(
    parameter int NUM_SRC = ivt_pkg::IVT_NUM_SRC
) (
    input wire logic [NUM_SRC-1:0] req,
    output logic any,
    output logic [ivt_pkg::IVT_SRC_W-1:0] idx,
    output logic [ivt_pkg::IVT_TRAP_W-1:0] trap
);
    import ivt_pkg::*;

    // Lowest index wins; the gap 0x62..0x67 is never produced
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = IVT_SRC_W'(i);
            end
        end
        if (idx < IVT_SRC_W'(IVT_GRP0_CNT)) begin
            trap = IVT_GRP0_TRAP + IVT_TRAP_W'(idx);
        end else begin
            trap = IVT_GRP1_TRAP + IVT_TRAP_W'(idx - IVT_SRC_W'(IVT_GRP0_CNT));
        end
    end
endmodule // ivt_src_map

//--- testbench/ivt_cpu_model.sv
// CPU core model: takes vectors and runs services of a set length.
// Assumes the vector handshake of the map runs on ref_clk.
`timescale 1ns/1ns
module ivt_cpu_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic vec_valid,
    input wire logic [3:0] ack_dly,
    input wire logic [7:0] svc_len,
    output logic vec_ack,
    output logic svc_done
);
    logic [3:0] wait_cnt;
    logic [7:0] svc_cnt;
    logic in_svc;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            vec_ack <= 1'b0;
            svc_done <= 1'b0;
            wait_cnt <= 4'h0;
            svc_cnt <= 8'h00;
            in_svc <= 1'b0;
        end else begin
            vec_ack <= 1'b0;
            svc_done <= 1'b0;
            if (vec_valid && !vec_ack) begin
                // A slow answer keeps the vector standing for some cycles
                if (wait_cnt == ack_dly) begin
                    vec_ack <= 1'b1;
                    wait_cnt <= 4'h0;
                    in_svc <= 1'b1;
                    svc_cnt <= 8'h00;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else if (in_svc) begin
                if (svc_cnt == svc_len) begin
                    svc_done <= 1'b1;
                    in_svc <= 1'b0;
                end else begin
                    svc_cnt <= svc_cnt + 8'h01;
                end
            end
        end
    end
endmodule // ivt_cpu_model

//--- testbench/interrupt_vector_and_trap_map_tb.sv
// Testbench of the vector and trap map with a CPU core model.
// Assumes the register map and vector handshake timing of the map core.
`timescale 1ns/1ns
module interrupt_vector_and_trap_map_tb;
    import ivt_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [35:0] src_req = 36'h0;
    logic [35:0] src_ack;
    logic [3:0] trap_a = 4'h0;
    logic trap_b = 1'b0;
    logic vec_valid, vec_is_trap, vec_ack, svc_done, irq;
    logic [6:0] vec_trap;
    logic [23:0] vec_addr;
    logic [3:0] ack_dly = 4'h0;
    logic [7:0] svc_len = 8'h04;
    int n_fail = 0;
    int comparisons = 0;

    ivt_core uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_req(src_req), .src_ack(src_ack),
        .trap_a(trap_a), .trap_b(trap_b), .vec_valid(vec_valid),
        .vec_is_trap(vec_is_trap), .vec_trap(vec_trap), .vec_addr(vec_addr),
        .vec_ack(vec_ack), .svc_done(svc_done), .irq(irq));
    ivt_cpu_model cpu (.ref_clk(ref_clk), .resetn(resetn),
        .vec_valid(vec_valid), .ack_dly(ack_dly), .svc_len(svc_len),
        .vec_ack(vec_ack), .svc_done(svc_done));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    task automatic wait_vec();
        for (int i = 0; i < 60 && vec_valid !== 1'b1; i++) @(negedge ref_clk);
        chk({23'h0, vec_valid}, 24'h1);
    endtask

    // One peripheral request, vectored and acknowledged one-hot
    task automatic irq_case(input int b, input logic [6:0] t, input int sh);
        @(posedge ref_clk);
        src_req <= 36'h1 << b;
        wait_vec();
        chk({17'h0, vec_trap}, {17'h0, t});
        chk(vec_addr, {8'hA5, 16'(t) << sh});
        chk({23'h0, vec_is_trap}, 24'h0);
        for (int i = 0; i < 20 && src_ack === 36'h0; i++) @(negedge ref_clk);
        chk(24'(src_ack >> b), 24'h1);
        @(posedge ref_clk);
        src_req <= 36'h0;
        repeat (12) @(posedge ref_clk);
    endtask

    // Reserved slots must never show up as a vector
    always @(negedge ref_clk) begin
        if (vec_valid === 1'b1 && vec_trap >= 7'h62 && vec_trap <= 7'h67) begin
            chk({17'h0, vec_trap}, 24'h0);
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(IVT_REG_SEG, 16'h0000);
        rd(IVT_REG_CFG, 16'h0000);
        rd(IVT_REG_FLAG, 16'h0000);
        rd(8'hFC, 16'h0000);
        wr(IVT_REG_SEG, 16'h00A5);
        // Requests are ignored while the enable bit is still clear
        src_req <= 36'h1 << 10;
        repeat (3) @(negedge ref_clk);
        chk({23'h0, vec_valid}, 24'h0);
        @(posedge ref_clk);
        src_req <= 36'h0;
        wr(IVT_REG_CFG, 16'h0004);
        rd(IVT_REG_SEG, 16'h00A5);
        irq_case(10, 7'h50, 2);
        irq_case(11, 7'h51, 2);
        irq_case(27, 7'h61, 2);
        irq_case(28, 7'h68, 2);
        irq_case(30, 7'h6A, 2);
        irq_case(33, 7'h6D, 2);
        irq_case(35, 7'h6F, 2);
        wr(IVT_REG_CFG, 16'h0005);
        ack_dly <= 4'h3;
        irq_case(27, 7'h61, 3);
        wr(IVT_REG_CFG, 16'h0004);
        svc_len <= 8'h1E;
        @(posedge ref_clk);
        trap_b <= 1'b1;
        @(posedge ref_clk);
        trap_b <= 1'b0;
        wait_vec();
        chk({17'h0, vec_trap}, 24'h00000A);
        chk(vec_addr, 24'hA50028);
        chk({23'h0, vec_is_trap}, 24'h1);
        repeat (4) @(posedge ref_clk);
        src_req <= 36'h1 << 35;
        repeat (6) @(negedge ref_clk);
        chk({23'h0, vec_valid}, 24'h0);
        @(posedge ref_clk);
        trap_a <= 4'h1;
        @(posedge ref_clk);
        trap_a <= 4'h0;
        wait_vec();
        chk({17'h0, vec_trap}, 24'h000002);
        chk(vec_addr, 24'hA50008);
        rd(IVT_REG_FLAG, 16'h0011);
        wr(IVT_REG_FLAG, 16'h0011);
        rd(IVT_REG_FLAG, 16'h0000);
        chk({23'h0, irq}, 24'h0);
        wait_vec();
        chk({17'h0, vec_trap}, 24'h00006F);
        chk(vec_addr, 24'hA501BC);
        for (int i = 0; i < 20 && src_ack === 36'h0; i++) @(negedge ref_clk);
        chk(24'(src_ack >> 35), 24'h1);
        @(posedge ref_clk);
        src_req <= 36'h0;
        svc_len <= 8'h04;
        // A class B trap cuts into the running interrupt service
        trap_b <= 1'b1;
        @(posedge ref_clk);
        trap_b <= 1'b0;
        wait_vec();
        chk({17'h0, vec_trap}, 24'h00000A);
        chk({23'h0, vec_is_trap}, 24'h1);
        repeat (12) @(posedge ref_clk);
        wr(IVT_REG_MASK, 16'h0001);
        repeat (2) @(negedge ref_clk);
        chk({23'h0, irq}, 24'h1);
        wr(IVT_REG_EVT, 16'h0007);
        repeat (2) @(negedge ref_clk);
        chk({23'h0, irq}, 24'h0);
        rd(IVT_REG_EVT, 16'h0000);
        tally_and_finish();
    end
endmodule // interrupt_vector_and_trap_map_tb
